// ### hdl/cbh_cfg.svh
// Constants shared by both ends of the codec byte host port.
// Behaviour
// - Capture request rises when a sample waits.
// - Capture request holds until all bytes read.
// - Playback request rises when room for sample.
// - Playback request holds until sample fully written.
// - Capture ack with read returns capture bytes.
// - Playback ack with write stores playback bytes.
// - Register select picks the direct register.
// - Read strobe starts register or sample read.
// - Write strobe starts register or sample write.
// - Chip select gates register cycles only.
// - All traffic uses one eight-bit bus.
// - Transceiver enable low during qualified strobes.
// - Direction low only during qualified reads.
// - Initialization ends within 70 or 90 ms.
// - Interrupt raised on transfer count underflow.
`ifndef CBH_CFG_SVH
`define CBH_CFG_SVH
`define CBH_CLK_NS 8
`define CBH_STROBE_NS 130
`define CBH_RECOVER_NS 140
`define CBH_SETUP_NS 25
`define CBH_HOLD_NS 10
`define CBH_INIT_SLOW_MS 70
`define CBH_INIT_FAST_MS 90
`define CBH_NS_PER_MS 1000000
`define CBH_SAMPLE_BYTES 4
`define CBH_FIFO_DEPTH 16
`define CBH_REG_CONTROL 2'h0
`define CBH_REG_STATUS 2'h1
`define CBH_REG_COUNT_LO 2'h2
`define CBH_REG_COUNT_HI 2'h3
`define CBH_BUS_IDLE 8'hff
`endif

// ### hdl/cbh_pkg.sv
// Types used by the host bus end of the codec byte host port.
package cbh_pkg;
    // Kinds of host cycle
    typedef enum logic [1:0] {
        CBH_PIO_READ,
        CBH_PIO_WRITE,
        CBH_DMA_READ,
        CBH_DMA_WRITE
    } cbh_cmd_t;
    // Phases of one host bus cycle
    typedef enum logic [2:0] {
        CBH_IDLE,
        CBH_SETUP,
        CBH_STROBE,
        CBH_HOLD,
        CBH_RECOVER
    } cbh_phase_t;
endpackage : cbh_pkg

// ### hdl/cbh_link_if.sv
// Pin bundle between host bus end and codec port end.
`timescale 1ns/1ps
`include "cbh_cfg.svh"
interface cbh_link_if;
    logic rd_n; // Read strobe
    logic wr_n; // Write strobe
    logic cs_n; // Chip select
    logic [1:0] register_select; // Direct register address
    logic capture_ack_n; // Capture DMA acknowledge
    logic playback_ack_n; // Playback DMA acknowledge
    logic [7:0] host_data; // Host drive value
    logic host_data_oe; // Host drives bus
    logic [7:0] dev_data; // Device drive value
    logic dev_data_oe; // Device drives bus
    logic [7:0] byte_bus; // Resolved bus level
    logic capture_request;
    logic playback_request;
    logic transceiver_enable_n;
    logic transceiver_direction;
    logic host_interrupt;
    // Resolved level; an undriven bus floats high like a pulled-up line
    assign byte_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : `CBH_BUS_IDLE);
    modport device (
        input rd_n, wr_n, cs_n, register_select, capture_ack_n, playback_ack_n, byte_bus,
        output dev_data, dev_data_oe, capture_request, playback_request,
        output transceiver_enable_n, transceiver_direction, host_interrupt
    );
    modport host (
        output rd_n, wr_n, cs_n, register_select, capture_ack_n, playback_ack_n,
        output host_data, host_data_oe,
        input byte_bus, capture_request, playback_request, host_interrupt
    );
endinterface : cbh_link_if

// ### hdl/cbh_device.sv
// Codec end of the byte host port, with its playback FIFO.
`timescale 1ns/1ps
`include "cbh_cfg.svh"
module cbh_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = `CBH_FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // Whole FIFO state, memory included
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } cbh_fifo_state_t;
    cbh_fifo_state_t st;
    cbh_fifo_state_t next_st;
    logic push;
    logic pop;
    // Honest flags straight from the count
    assign in_ready = (st.count != (AW+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data = st.mem[st.rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // Pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wptr] = in_data;
            next_st.wptr = (st.wptr == AW'(DEPTH-1)) ? '0 : st.wptr + 1'b1;
        end
        if (pop) begin
            next_st.rptr = (st.rptr == AW'(DEPTH-1)) ? '0 : st.rptr + 1'b1;
        end
        // Simultaneous push and pop leaves count unchanged
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end
    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : cbh_fifo

module cbh_device #(
    parameter int INIT_SLOW_CYC = `CBH_INIT_SLOW_MS * (`CBH_NS_PER_MS / `CBH_CLK_NS),
    parameter int INIT_FAST_CYC = `CBH_INIT_FAST_MS * (`CBH_NS_PER_MS / `CBH_CLK_NS)
) (
    input wire logic ref_clk,
    input wire logic rstn,
    cbh_link_if.device link,
    input wire logic crystal_fast,
    input wire logic cap_valid,
    output logic cap_ready,
    input wire logic [8*`CBH_SAMPLE_BYTES-1:0] cap_data,
    output logic play_valid,
    input wire logic play_ready,
    output logic [8*`CBH_SAMPLE_BYTES-1:0] play_data,
    output logic init_done,
    output logic [7:0] control_byte
);
    localparam int SW = 8 * `CBH_SAMPLE_BYTES;
    localparam int BW = $clog2(`CBH_SAMPLE_BYTES);
    // All device state in one record
    typedef struct packed {
        logic [4:0] sync1; // First sync stage, read only by sync2
        logic [4:0] sync2; // Usable pin levels
        logic [7:0] bus1;
        logic [7:0] bus2;
        logic [1:0] sel1;
        logic [1:0] sel2;
        logic rd_prev;
        logic wr_prev;
        logic wr_pio; // Write qualifiers latched while strobe low
        logic wr_play;
        logic [1:0] wr_sel;
        logic [7:0] wr_byte;
        logic started;
        logic [31:0] init_count;
        logic ready;
        logic [3:0][7:0] regs;
        logic [15:0] xfer_count;
        logic irq;
        logic [SW-1:0] cap_buf;
        logic cap_full;
        logic cap_rdy; // Capture slot free, kept in a flop
        logic [BW-1:0] cap_idx;
        logic [SW-1:0] play_acc;
        logic [BW-1:0] play_idx;
        logic play_push;
        logic play_req;
        logic [7:0] dout;
        logic doe;
        logic ten_n;
        logic tdir;
    } cbh_dev_state_t;
    cbh_dev_state_t st;
    cbh_dev_state_t next_st;
    logic rd_act, wr_act, pio, cdma, pdma, qual;
    logic fifo_ready;
    logic [4:0] pins;
    // Pin vector order: rd, wr, cs, cack, pack
    assign pins = {~link.rd_n, ~link.wr_n, ~link.cs_n, ~link.capture_ack_n,
                   ~link.playback_ack_n};
    assign rd_act = st.sync2[4];
    assign wr_act = st.sync2[3];
    assign pio = st.sync2[2];
    assign cdma = st.sync2[1];
    assign pdma = st.sync2[0];
    assign qual = pio || cdma || pdma;
    // Status byte seen on a register read
    function automatic logic [7:0] status_byte(input cbh_dev_state_t s);
        status_byte = {4'h0, s.ready, s.irq, s.cap_full, s.play_req};
    endfunction : status_byte

    cbh_fifo #(.WIDTH(SW), .DEPTH(`CBH_FIFO_DEPTH)) u_play_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_valid(st.play_push),
        .in_ready(fifo_ready),
        .in_data(st.play_acc),
        .out_valid(play_valid),
        .out_ready(play_ready),
        .out_data(play_data)
    );

    // Next-state logic for the whole port
    always_comb begin
        next_st = st;
        // Two-stage synchronisers for every pin
        next_st.sync1 = pins;
        next_st.sync2 = st.sync1;
        next_st.bus1 = link.byte_bus;
        next_st.bus2 = st.bus1;
        next_st.sel1 = link.register_select;
        next_st.sel2 = st.sel1;
        next_st.rd_prev = rd_act;
        next_st.wr_prev = wr_act;
        next_st.play_push = 1'b0;
        if (!st.started) begin
            next_st.started = 1'b1;
            next_st.init_count = crystal_fast ? INIT_FAST_CYC : INIT_SLOW_CYC;
        end else if (st.init_count != '0) begin
            next_st.init_count = st.init_count - 1'b1;
        end else begin
            next_st.ready = 1'b1;
        end
        if (wr_act) begin
            next_st.wr_pio = pio;
            next_st.wr_play = pdma;
            next_st.wr_sel = st.sel2;
            next_st.wr_byte = st.bus2;
        end
        // read cycle starts on falling strobe
        if (rd_act && !st.rd_prev) begin
            if (cdma) begin
                next_st.dout = st.cap_buf[8*st.cap_idx +: 8];
                next_st.cap_idx = st.cap_idx + 1'b1;
                if (st.cap_idx == BW'(`CBH_SAMPLE_BYTES-1)) begin
                    next_st.cap_full = 1'b0;
                    next_st.cap_idx = '0;
                end
            end else if (pio) begin
                next_st.dout = (st.sel2 == `CBH_REG_STATUS) ? status_byte(st) : st.regs[st.sel2];
            end
        end
        // write cycle ends on rising strobe
        if (!wr_act && st.wr_prev) begin
            if (st.wr_play) begin
                next_st.play_acc[8*st.play_idx +: 8] = st.wr_byte;
                next_st.play_idx = st.play_idx + 1'b1;
                if (st.play_idx == BW'(`CBH_SAMPLE_BYTES-1)) begin
                    next_st.play_push = 1'b1;
                    next_st.play_idx = '0;
                end
            end else if (st.wr_pio) begin
                next_st.regs[st.wr_sel] = st.wr_byte;
                // Status write clears the interrupt
                if (st.wr_sel == `CBH_REG_STATUS) begin
                    next_st.irq = 1'b0;
                end
            end
        end
        if (next_st.play_push || (st.cap_full && !next_st.cap_full)) begin
            if (st.xfer_count == '0) begin
                // Set wins over a same-cycle clear
                next_st.irq = 1'b1;
                next_st.xfer_count = {st.regs[`CBH_REG_COUNT_HI], st.regs[`CBH_REG_COUNT_LO]};
            end else begin
                next_st.xfer_count = st.xfer_count - 1'b1;
            end
        end
        if (cap_valid && cap_ready) begin
            next_st.cap_buf = cap_data;
            next_st.cap_full = 1'b1;
        end
        // request while FIFO has room, held mid-sample
        next_st.play_req = st.ready && fifo_ready && !next_st.play_push;
        // drive bus only on qualified read
        next_st.doe = rd_act && (pio || cdma);
        next_st.ten_n = !((rd_act || wr_act) && qual);
        next_st.tdir = !(rd_act && qual);
        // Capture slot free once initialised, registered so the output is a flop
        next_st.cap_rdy = next_st.ready && !next_st.cap_full;
    end

    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.ten_n <= 1'b1;
            st.tdir <= 1'b1;
            st.dout <= `CBH_BUS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign link.dev_data = st.dout;
    assign link.dev_data_oe = st.doe;
    assign link.capture_request = st.cap_full;
    assign link.playback_request = st.play_req;
    assign link.transceiver_enable_n = st.ten_n;
    assign link.transceiver_direction = st.tdir;
    assign link.host_interrupt = st.irq;
    // Capture slot free once initialised
    assign cap_ready = st.cap_rdy;
    assign init_done = st.ready;
    assign control_byte = st.regs[`CBH_REG_CONTROL];
endmodule : cbh_device

// ### hdl/cbh_host.sv
// Host bus end of the byte host port.
`timescale 1ns/1ps
`include "cbh_cfg.svh"
module cbh_host (
    input wire logic ref_clk,
    input wire logic rstn,
    cbh_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire cbh_pkg::cbh_cmd_t cmd_kind,
    input wire logic [1:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    output logic resp_valid,
    output logic [7:0] resp_data,
    output logic capture_pending,
    output logic playback_pending,
    output logic irq_seen
);
    // Least times round up to whole cycles
    localparam logic [7:0] SETUP_CYC = 8'((`CBH_SETUP_NS + `CBH_CLK_NS - 1) / `CBH_CLK_NS);
    localparam logic [7:0] STROBE_CYC = 8'((`CBH_STROBE_NS + `CBH_CLK_NS - 1) / `CBH_CLK_NS);
    localparam logic [7:0] HOLD_CYC = 8'((`CBH_HOLD_NS + `CBH_CLK_NS - 1) / `CBH_CLK_NS);
    localparam logic [7:0] RECOVER_CYC = 8'((`CBH_RECOVER_NS + `CBH_CLK_NS - 1) / `CBH_CLK_NS);
    // All host state in one record
    typedef struct packed {
        cbh_pkg::cbh_phase_t phase;
        cbh_pkg::cbh_cmd_t kind;
        logic [7:0] count;
        logic [7:0] bus1; // First sync stage
        logic [7:0] bus2;
        logic [2:0] in1;
        logic [2:0] in2;
        logic rd_n;
        logic wr_n;
        logic cs_n;
        logic cack_n;
        logic pack_n;
        logic [1:0] sel;
        logic [7:0] dout;
        logic doe;
        logic rsp;
        logic [7:0] rdata;
    } cbh_host_state_t;
    cbh_host_state_t st;
    cbh_host_state_t next_st;
    // Read or write decode used in several phases
    function automatic logic is_read(input cbh_pkg::cbh_cmd_t k);
        is_read = (k == cbh_pkg::CBH_PIO_READ) || (k == cbh_pkg::CBH_DMA_READ);
    endfunction : is_read

    // Cycle sequencer
    always_comb begin
        next_st = st;
        next_st.bus1 = link.byte_bus;
        next_st.bus2 = st.bus1;
        next_st.in1 = {link.capture_request, link.playback_request, link.host_interrupt};
        next_st.in2 = st.in1;
        next_st.rsp = 1'b0;
        if (st.count != '0) begin
            next_st.count = st.count - 1'b1;
        end
        unique case (st.phase)
            cbh_pkg::CBH_IDLE: begin
                if (cmd_valid) begin
                    next_st.kind = cmd_kind;
                    next_st.sel = cmd_addr;
                    next_st.cs_n = !((cmd_kind == cbh_pkg::CBH_PIO_READ) || (cmd_kind == cbh_pkg::CBH_PIO_WRITE));
                    next_st.cack_n = (cmd_kind != cbh_pkg::CBH_DMA_READ);
                    next_st.pack_n = (cmd_kind != cbh_pkg::CBH_DMA_WRITE);
                    next_st.dout = cmd_data;
                    next_st.doe = !is_read(cmd_kind);
                    next_st.count = SETUP_CYC - 1'b1;
                    next_st.phase = cbh_pkg::CBH_SETUP;
                end
            end
            cbh_pkg::CBH_SETUP: begin
                if (st.count == '0) begin
                    next_st.rd_n = !is_read(st.kind);
                    next_st.wr_n = is_read(st.kind);
                    next_st.count = STROBE_CYC - 1'b1;
                    next_st.phase = cbh_pkg::CBH_STROBE;
                end
            end
            cbh_pkg::CBH_STROBE: begin
                if (st.count == '0) begin
                    // Read data long settled by now
                    next_st.rdata = st.bus2;
                    next_st.rd_n = 1'b1;
                    next_st.wr_n = 1'b1;
                    next_st.count = HOLD_CYC - 1'b1;
                    next_st.phase = cbh_pkg::CBH_HOLD;
                end
            end
            cbh_pkg::CBH_HOLD: begin
                if (st.count == '0) begin
                    next_st.cs_n = 1'b1;
                    next_st.cack_n = 1'b1;
                    next_st.pack_n = 1'b1;
                    next_st.doe = 1'b0;
                    next_st.rsp = 1'b1;
                    next_st.count = RECOVER_CYC - 1'b1;
                    next_st.phase = cbh_pkg::CBH_RECOVER;
                end
            end
            cbh_pkg::CBH_RECOVER: begin
                if (st.count == '0) begin
                    next_st.phase = cbh_pkg::CBH_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.phase <= cbh_pkg::CBH_IDLE;
            st.rd_n <= 1'b1;
            st.wr_n <= 1'b1;
            st.cs_n <= 1'b1;
            st.cack_n <= 1'b1;
            st.pack_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign link.rd_n = st.rd_n;
    assign link.wr_n = st.wr_n;
    assign link.cs_n = st.cs_n;
    assign link.capture_ack_n = st.cack_n;
    assign link.playback_ack_n = st.pack_n;
    assign link.register_select = st.sel;
    assign link.host_data = st.dout;
    assign link.host_data_oe = st.doe;
    assign cmd_ready = (st.phase == cbh_pkg::CBH_IDLE);
    assign resp_valid = st.rsp;
    assign resp_data = st.rdata;
    assign capture_pending = st.in2[2];
    assign playback_pending = st.in2[1];
    assign irq_seen = st.in2[0];
endmodule : cbh_host

// ### tb/cbh_link_checker.sv
// Concurrent checks on the pins between the host end and the codec end.
`timescale 1ns/1ps
module cbh_link_checker (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic cs_n,
    input wire logic capture_ack_n,
    input wire logic playback_ack_n,
    input wire logic dev_data_oe,
    input wire logic capture_request,
    input wire logic playback_request,
    input wire logic transceiver_enable_n,
    input wire logic transceiver_direction
);
    // Pins are synchronised inside the codec, so each check except the two request-fall checks waits five cycles of steady level
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    AST_TEN_ON: assert property ((!(rd_n && wr_n) && (!cs_n || !capture_ack_n || !playback_ack_n))[*5]
        |-> !transceiver_enable_n) else $error("transceiver enable high during qualified strobe");
    AST_TEN_OFF: assert property ((rd_n && wr_n)[*5] |-> transceiver_enable_n)
        else $error("transceiver enable low while idle");
    AST_DIR_LOW: assert property ((!rd_n && (!cs_n || !capture_ack_n || !playback_ack_n))[*5]
        |-> !transceiver_direction) else $error("direction high during qualified read");
    AST_DIR_HIGH: assert property (rd_n[*5] |-> transceiver_direction)
        else $error("direction low without read strobe");
    AST_OE_READ: assert property ((!rd_n && (!cs_n || !capture_ack_n))[*5] |-> dev_data_oe)
        else $error("bus not driven during qualified read");
    AST_OE_OFF: assert property ((rd_n || (cs_n && capture_ack_n))[*5] |-> !dev_data_oe)
        else $error("bus driven outside qualified read");
    // capture drop only in a read
    AST_CAP_FALL: assert property ($fell(capture_request) |-> !rd_n && !capture_ack_n)
        else $error("capture request fell outside a capture read");
    AST_PLAY_FALL: assert property ($fell(playback_request) |-> wr_n && !$past(wr_n, 8))
        else $error("playback request fell without a finished write");
endmodule : cbh_link_checker

// ### tb/tb_top.sv
// Self-checking bench joining the host end and the codec end of the byte host port.
`timescale 1ns/1ps
`include "cbh_cfg.svh"
module tb_top;
    logic ref_clk = 1'b0; // Bench clock
    logic rstn = 1'b0; // Held low from time zero
    logic crystal_fast = 1'b0; // Crystal choice
    logic cap_valid = 1'b0; // Capture sample offer
    logic [31:0] cap_data = 32'h0;
    logic play_ready = 1'b0; // Playback drain, stalled at first
    logic cmd_valid = 1'b0;
    cbh_pkg::cbh_cmd_t cmd_kind = cbh_pkg::CBH_PIO_READ;
    logic [1:0] cmd_addr = 2'h0;
    logic [7:0] cmd_data = 8'h00;
    logic cap_ready, play_valid, init_done, cmd_ready, resp_valid, capture_pending, playback_pending, irq_seen;
    logic [31:0] play_data;
    logic [7:0] control_byte, resp_data, rb;
    logic [31:0] w; // Current random word
    logic [31:0] word_q[$]; // Playback words still owed
    int n_mismatch = 0;
    int cmp_count = 0;
    int seed = 32'h771e4603;
    int n;

    // Free-running clock
    always #4 ref_clk = ~ref_clk;

    cbh_link_if link();
    // Small init counts keep the run short
    cbh_device #(.INIT_SLOW_CYC(20), .INIT_FAST_CYC(30)) cbh_device_i (.ref_clk(ref_clk), .rstn(rstn),
        .link(link), .crystal_fast(crystal_fast), .cap_valid(cap_valid), .cap_ready(cap_ready),
        .cap_data(cap_data), .play_valid(play_valid), .play_ready(play_ready), .play_data(play_data),
        .init_done(init_done), .control_byte(control_byte));
    cbh_host cbh_host_i (.ref_clk(ref_clk), .rstn(rstn), .link(link), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .resp_valid(resp_valid), .resp_data(resp_data), .capture_pending(capture_pending),
        .playback_pending(playback_pending), .irq_seen(irq_seen));
    cbh_link_checker cbh_link_checker_i (.ref_clk(ref_clk), .rstn(rstn), .rd_n(link.rd_n), .wr_n(link.wr_n),
        .cs_n(link.cs_n), .capture_ack_n(link.capture_ack_n), .playback_ack_n(link.playback_ack_n),
        .dev_data_oe(link.dev_data_oe), .capture_request(link.capture_request),
        .playback_request(link.playback_request), .transceiver_enable_n(link.transceiver_enable_n),
        .transceiver_direction(link.transceiver_direction));

    // Verdict and end of run
    task automatic end_sim();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // A bounded wait ran out
    task automatic give_up(input string what);
        $display("[ERR] %s expected 1 seen 0", what);
        n_mismatch++;
        end_sim();
    endtask : give_up

    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", what, e, g);
            n_mismatch++;
        end
    endtask : chk_byte

    task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", what, e, g);
            n_mismatch++;
        end
    endtask : chk_word

    task automatic chk_flag(input string what, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %b seen %b", what, e, g);
            n_mismatch++;
        end
    endtask : chk_flag

    // Byte b of a sample, low byte first
    function automatic logic [7:0] sample_byte(input logic [31:0] s, input int b);
        sample_byte = s[8*b+:8];
    endfunction : sample_byte

    // One host cycle; commands are spaced by waiting for cmd_ready
    task automatic do_cmd(input cbh_pkg::cbh_cmd_t k, input logic [1:0] a, input logic [7:0] d,
                          output logic [7:0] r);
        int t;
        t = 0;
        @(negedge ref_clk);
        while (cmd_ready !== 1'b1) begin
            t++;
            if (t > 100) give_up("cmd_ready");
            @(negedge ref_clk);
        end
        cmd_valid = 1'b1;
        cmd_kind = k;
        cmd_addr = a;
        cmd_data = d;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        t = 0;
        while (resp_valid !== 1'b1) begin
            t++;
            if (t > 60) give_up("resp_valid");
            @(negedge ref_clk);
        end
        r = resp_data;
    endtask : do_cmd

    // Reset, then init_done is sampled between the slow and the fast count and again past both
    task automatic do_reset(input logic fast);
        @(negedge ref_clk);
        rstn = 1'b0;
        crystal_fast = fast;
        repeat (16) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (25) @(negedge ref_clk);
        chk_flag("init_done early", ~fast, init_done);
        repeat (15) @(negedge ref_clk);
        chk_flag("init_done late", 1'b1, init_done);
    endtask : do_reset

    initial begin
        // Second reset in mid-run also switches crystal
        do_reset(1'b0);
        do_reset(1'b1);
        repeat (4) @(negedge ref_clk);
        chk_flag("playback_pending", 1'b1, playback_pending);
        for (int i = 0; i < 4; i++) begin
            w = (i == 0) ? 32'h0 : (i == 1) ? 32'hff : $random(seed);
            do_cmd(cbh_pkg::CBH_PIO_WRITE, `CBH_REG_CONTROL, w[7:0], rb);
            do_cmd(cbh_pkg::CBH_PIO_READ, `CBH_REG_CONTROL, 8'h00, rb);
            chk_byte("control readback", w[7:0], rb);
            chk_byte("control_byte", w[7:0], control_byte);
        end
        // Large reload so only the first sample underflows
        do_cmd(cbh_pkg::CBH_PIO_WRITE, `CBH_REG_COUNT_LO, 8'hff, rb);
        do_cmd(cbh_pkg::CBH_PIO_WRITE, `CBH_REG_COUNT_HI, 8'hff, rb);
        // Offer one capture sample
        w = $random(seed);
        cap_data = w;
        cap_valid = 1'b1;
        n = 0;
        while (cap_ready !== 1'b1) begin
            n++;
            if (n > 50) give_up("cap_ready");
            @(negedge ref_clk);
        end
        @(negedge ref_clk);
        cap_valid = 1'b0;
        repeat (10) @(negedge ref_clk);
        chk_flag("capture_pending", 1'b1, capture_pending);
        for (int b = 0; b < 4; b++) begin
            do_cmd(cbh_pkg::CBH_DMA_READ, 2'h0, 8'h00, rb);
            chk_byte("capture byte", sample_byte(w, b), rb);
            if (b < 3) chk_flag("capture_pending held", 1'b1, capture_pending);
        end
        repeat (10) @(negedge ref_clk);
        chk_flag("capture_pending done", 1'b0, capture_pending);
        // underflow interrupt, seen in status and cleared by a write
        chk_flag("irq_seen", 1'b1, irq_seen);
        do_cmd(cbh_pkg::CBH_PIO_READ, `CBH_REG_STATUS, 8'h00, rb);
        // Ready, interrupt, no capture pending, playback room
        chk_byte("status byte", 8'h0d, rb);
        do_cmd(cbh_pkg::CBH_PIO_WRITE, `CBH_REG_STATUS, 8'h00, rb);
        repeat (10) @(negedge ref_clk);
        chk_flag("irq_seen cleared", 1'b0, irq_seen);
        // fill the playback FIFO while its drain is stalled
        for (int s = 0; s < `CBH_FIFO_DEPTH; s++) begin
            w = (s == 0) ? 32'hffffffff : $random(seed);
            word_q.push_back(w);
            for (int b = 0; b < 4; b++) begin
                do_cmd(cbh_pkg::CBH_DMA_WRITE, 2'h0, sample_byte(w, b), rb);
                if (b < 3) chk_flag("playback_pending held", 1'b1, playback_pending);
            end
        end
        repeat (10) @(negedge ref_clk);
        chk_flag("playback_pending full", 1'b0, playback_pending);
        // Drain: a word shown at a falling edge moves at the next rising edge
        play_ready = 1'b1;
        n = 0;
        while (word_q.size() > 0) begin
            if (play_valid === 1'b1) chk_word("play_data", word_q.pop_front(), play_data);
            n++;
            if (n > 200) give_up("play_valid");
            @(negedge ref_clk);
        end
        repeat (10) @(negedge ref_clk);
        chk_flag("play_valid empty", 1'b0, play_valid);
        chk_flag("playback_pending again", 1'b1, playback_pending);
        end_sim();
    end
endmodule : tb_top
